// ===== rpsa_pkg.sv
// shared constants and types of the radio packet sequencer support logic
package rpsa_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US = 1000;
    localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
    localparam int TURNAROUND_US = 40;
    // widths of configuration fields
    localparam int GAP_W = 16;
    localparam int GAPCNT_W = 24;
    localparam int BITS_W = 4;
    localparam int BYTE_W = 8;
    localparam int PTR_W = 32;
    localparam int MODE_W = 4;
    // shortcut bit positions
    localparam int SC_END_DISABLE = 0;
    localparam int SC_DIS_TRANSMIT_RAMPUP_TASK = 1;
    localparam int SC_DIS_RECEIVE_RAMPUP_TASK = 2;
    localparam int SC_W = 3;
    // device address matching layout
    localparam int DA_ENTRIES = 8;
    localparam int DA_LOW_W = 32;
    localparam int DA_HIGH_W = 16;
    localparam int DA_BITS = DA_LOW_W + DA_HIGH_W;
    localparam int DA_BYTES = DA_BITS / BYTE_W;
    localparam int DA_IDX_W = 3;
    localparam int DA_CNT_W = 3;
    localparam int TX_ADDRESS_TYPE_BIT_BIT = 6;
    localparam int DACFG_EN_LSB = 0;
    localparam int DACFG_TX_ADDRESS_TYPE_BIT_LSB = 8;
    // byte_order_sel value for little-endian packets
    localparam logic ORDER_LITTLE = 1'b0;
    // bit counter
    localparam int BC_W = 20;
    // fields walked by the transfer engine, in on-air order
    typedef enum {F_IDLE, F_S0, F_LEN, F_S1, F_PAY} rpsa_field_e;
endpackage

// ===== rpsa_stream_if.sv
// byte stream carrier between the transfer engine and its fifo
`timescale 1ns/1ps
interface rpsa_stream_if #(parameter int W = 8);
    logic in_valid;  // producer has a word
    logic in_ready;  // fifo takes it
    logic [W-1:0] in_data;  // word in
    logic out_valid;  // fifo holds a word
    logic out_ready;  // consumer takes it
    logic [W-1:0] out_data;  // head word
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ===== rpsa_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module rpsa_fifo #(
    parameter int W = 8,  // word width
    parameter int D = 4  // depth in words
) (
    input wire logic clk,  // system clock
    input wire logic rst_b,  // async reset, active low
    input wire logic flush,  // drop all contents
    rpsa_stream_if.fifo s  // both sides of the fifo
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(D);
    localparam logic [AW-1:0] LAST_IX = AW'(D - 1);

    logic [W-1:0] mem_q [D];  // storage
    logic [AW-1:0] wp_q;  // write index
    logic [AW-1:0] rp_q;  // read index
    logic [CW-1:0] cnt_q;  // words held
    logic push;
    logic pop;

    // honest flags from the count
    assign s.in_ready = (cnt_q != FULL_CNT);
    assign s.out_valid = (cnt_q != '0);
    assign s.out_data = mem_q[rp_q];
    assign push = s.in_valid & s.in_ready;
    assign pop = s.out_valid & s.out_ready;

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= s.in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == LAST_IX) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == LAST_IX) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end

    // never over- or underflow
    property p_fifo_bounds;
        @(posedge clk) disable iff (!rst_b) cnt_q <= FULL_CNT;
    endproperty
    a_fifo_bounds: assert property (p_fifo_bounds) else $error("fifo count beyond depth");
endmodule

// ===== rpsa_top.sv
// packet support logic: interframe gap, address match, bit counter, packet transfer
`timescale 1ns/1ps
// Overview of operation
// - hold programmed gap, raised to turnaround if shorter, from last rx bit
// - gap and shortcut settings take effect directly
// - gap runs from last bit to first tx bit
// - gap enforced only with end/disabled shortcuts
// - data-rate setting latched at ramp-up tasks
// - address match only in little-endian receive
// - first 48 payload bits, header bit 6
// - eight address entries compared at once
// - each entry enabled for matching independently
// - counter start/halt tasks, hit on compare
// - counting continues, new compare honoured
// - counter cleared on halt, stop, disable, end
// - one pointer, staged and latched at start
// - end after last bit, disabled acknowledges
// - fields moved in order, add-on follows payload
// - every field padded to whole bytes
// - sizes from config, payload from length
// - payload truncated at cap, memory bounded
// - cap counts payload and add-on only
// - length field kept, crc length capped
module rpsa_top #(
    parameter int FIFO_D = 4,  // fifo depth in bytes
    parameter int TURN_US = rpsa_pkg::TURNAROUND_US  // turnaround time in us
) (
    input wire logic clk,  // system clock, 100 MHz
    input wire logic rst_b,  // async reset, active low
    input wire logic [rpsa_pkg::GAP_W-1:0] interframe_gap_us,  // gap in us
    input wire logic [rpsa_pkg::SC_W-1:0] shortcut_links,  // shortcut enables
    input wire logic [rpsa_pkg::MODE_W-1:0] mode_sel,  // staged data-rate setting
    output logic [rpsa_pkg::MODE_W-1:0] mode_active,  // latched data-rate setting
    input wire logic transmit_rampup_task,  // tx ramp-up pulse
    input wire logic receive_rampup_task,  // rx ramp-up pulse
    input wire logic start_task,  // start pulse
    input wire logic stop_task,  // stop pulse
    input wire logic disable_task,  // disable pulse
    input wire logic last_air_bit,  // last bit on air, pulse
    input wire logic air_bit_tick,  // one bit on air, pulse
    output logic end_event,  // packet done, pulse
    output logic disabled_event,  // disable done, pulse
    output logic gap_busy,  // gap timer running
    output logic tx_first_bit,  // gap elapsed, pulse
    input wire logic bitcount_begin_task,  // counter start pulse
    input wire logic bitcount_halt_task,  // counter stop pulse
    input wire logic [rpsa_pkg::BC_W-1:0] bitcount_compare,  // compare value
    output logic bitcount_hit_event,  // compare reached, pulse
    output logic [rpsa_pkg::BC_W-1:0] bit_count,  // counter value
    input wire logic byte_order_sel,  // packet byte order
    input wire logic [rpsa_pkg::DA_ENTRIES*rpsa_pkg::DA_LOW_W-1:0] devaddr_low_word,  // low words
    input wire logic [rpsa_pkg::DA_ENTRIES*rpsa_pkg::DA_HIGH_W-1:0] devaddr_high_half,  // high parts
    input wire logic [2*rpsa_pkg::DA_ENTRIES-1:0] devaddr_match_config,  // enables, type bits
    output logic devmatch_event,  // address matched, pulse
    output logic devmiss_event,  // no address matched, pulse
    output logic [rpsa_pkg::DA_IDX_W-1:0] devmatch_index,  // matching entry
    input wire logic [rpsa_pkg::PTR_W-1:0] packet_ram_pointer,  // staged pointer
    input wire logic [rpsa_pkg::BITS_W-1:0] hdr_zero_bits,  // header zero size
    input wire logic [rpsa_pkg::BITS_W-1:0] length_field_bits,  // length size
    input wire logic [rpsa_pkg::BITS_W-1:0] hdr_one_bits,  // header one size
    input wire logic [rpsa_pkg::BYTE_W-1:0] static_addon_len,  // add-on bytes
    input wire logic [rpsa_pkg::BYTE_W-1:0] payload_byte_cap,  // payload+add-on cap
    output logic [rpsa_pkg::BYTE_W-1:0] crc_len_bytes,  // length used by crc
    output logic truncated,  // payload was cut
    output logic mem_req,  // memory access request
    output logic mem_we,  // write when high
    output logic [rpsa_pkg::PTR_W-1:0] mem_addr,  // byte address
    output logic [rpsa_pkg::BYTE_W-1:0] mem_wdata,  // write byte
    input wire logic mem_gnt,  // access done this cycle
    input wire logic [rpsa_pkg::BYTE_W-1:0] mem_rdata,  // read byte, valid with grant
    output logic air_tx_valid,  // byte for the modulator
    input wire logic air_tx_ready,  // modulator takes it
    output logic [rpsa_pkg::BYTE_W-1:0] air_tx_byte,  // byte to send
    input wire logic air_rx_valid,  // byte from the demodulator
    output logic air_rx_ready,  // fifo takes it
    input wire logic [rpsa_pkg::BYTE_W-1:0] air_rx_byte  // received byte
);
    import rpsa_pkg::*;

    localparam logic [GAPCNT_W-1:0] CYC_US = GAPCNT_W'(CYC_PER_US);
    localparam logic [GAP_W-1:0] TURN = GAP_W'(TURN_US);
    localparam logic [BYTE_W-1:0] ROUND = 8'h07;
    localparam logic [DA_CNT_W-1:0] DA_LAST = DA_CNT_W'(DA_BYTES - 1);

    rpsa_stream_if #(.W(BYTE_W)) st ();  // fifo sides

    logic txdir_q;  // transfer direction, 1 = transmit
    logic [GAPCNT_W-1:0] gap_q;  // gap cycles left
    logic [GAP_W-1:0] gap_eff;  // effective gap in us
    logic gap_en;  // shortcuts allow gap
    rpsa_field_e fs_q;  // current field
    logic [BYTE_W:0] rem_q;  // bytes left in field
    logic [PTR_W-1:0] addr_q;  // active pointer
    logic [BYTE_W-1:0] len_q;  // length byte seen
    logic [BYTE_W-1:0] hz_q;  // header zero byte seen
    logic [BYTE_W:0] req_tot;  // requested payload plus add-on
    logic [BYTE_W-1:0] pay_tot;  // bytes in payload region
    logic [BYTE_W-1:0] s0_by;  // header zero bytes
    logic [BYTE_W-1:0] lf_by;  // length bytes
    logic [BYTE_W-1:0] s1_by;  // header one bytes
    logic fire;  // memory byte moved
    logic [BYTE_W-1:0] pass;  // byte crossing the memory side
    logic bc_run_q;  // counter running
    logic [BC_W-1:0] bc_nx;  // next count
    logic [DA_CNT_W-1:0] da_n_q;  // address bytes taken
    logic da_full_q;  // all address bytes taken
    logic [DA_BITS-1:0] da_sh_q;  // received address
    logic da_go_q;  // compare now
    logic da_on;  // matching allowed
    logic [DA_ENTRIES-1:0] da_hit;  // per-entry match

    // byte counts padded to whole bytes
    assign s0_by = BYTE_W'((hdr_zero_bits + ROUND) / BYTE_W);
    assign lf_by = BYTE_W'((length_field_bits + ROUND) / BYTE_W);
    assign s1_by = BYTE_W'((hdr_one_bits + ROUND) / BYTE_W);
    // payload region from stored length, capped; header fields stay outside the cap
    assign req_tot = {1'b0, len_q} + {1'b0, static_addon_len};
    assign pay_tot = (req_tot > {1'b0, payload_byte_cap}) ? payload_byte_cap : req_tot[BYTE_W-1:0];

    // ramp-up tasks latch the data-rate setting and the direction
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_active <= '0;
            txdir_q <= 1'b0;
        end else if (transmit_rampup_task | receive_rampup_task) begin
            mode_active <= mode_sel;
            txdir_q <= transmit_rampup_task;
        end
    end

    // gap enforcement, settings read live with no shadow copy
    assign gap_en = shortcut_links[SC_END_DISABLE]
        & (shortcut_links[SC_DIS_TRANSMIT_RAMPUP_TASK] | shortcut_links[SC_DIS_RECEIVE_RAMPUP_TASK]);
    assign gap_eff = (interframe_gap_us < TURN) ? TURN : interframe_gap_us;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_q <= '0;
            tx_first_bit <= 1'b0;
        end else begin
            tx_first_bit <= (gap_q == GAPCNT_W'(1));
            if (last_air_bit & !txdir_q & gap_en) begin
                gap_q <= GAPCNT_W'(gap_eff) * CYC_US;
            end else if (gap_q != '0) begin
                gap_q <= gap_q - 1'b1;
            end
        end
    end
    assign gap_busy = (gap_q != '0);

    // end and disabled events
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            end_event <= 1'b0;
            disabled_event <= 1'b0;
        end else begin
            end_event <= last_air_bit;
            disabled_event <= disable_task;
        end
    end

    // bit counter
    assign bc_nx = bit_count + 1'b1;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bc_run_q <= 1'b0;
            bit_count <= '0;
            bitcount_hit_event <= 1'b0;
        end else begin
            bitcount_hit_event <= 1'b0;
            if (bitcount_halt_task | stop_task | disable_task | end_event) begin
                bc_run_q <= 1'b0;
                bit_count <= '0;
            end else if (bitcount_begin_task) begin
                bc_run_q <= 1'b1;
                bit_count <= '0;
            end else if (bc_run_q & air_bit_tick) begin
                bit_count <= bc_nx;
                bitcount_hit_event <= (bc_nx == bitcount_compare);
            end
        end
    end

    // transfer engine: fields walked in air order
    assign fire = mem_req & mem_gnt;
    assign pass = txdir_q ? mem_rdata : st.out_data;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_q <= F_IDLE;
            rem_q <= '0;
            addr_q <= '0;
        end else if (stop_task | disable_task) begin
            fs_q <= F_IDLE;
            rem_q <= '0;
        end else if (start_task) begin
            fs_q <= F_S0;
            rem_q <= {1'b0, s0_by};
            addr_q <= packet_ram_pointer;
        end else if (fs_q != F_IDLE && rem_q == '0) begin
            case (fs_q)
                F_S0: begin
                    fs_q <= F_LEN;
                    rem_q <= {1'b0, lf_by};
                end
                F_LEN: begin
                    fs_q <= F_S1;
                    rem_q <= {1'b0, s1_by};
                end
                F_S1: begin
                    // add-on follows the payload in the same region
                    fs_q <= F_PAY;
                    rem_q <= {1'b0, pay_tot};
                end
                default: begin
                    fs_q <= F_IDLE;
                end
            endcase
        end else if (fire) begin
            rem_q <= rem_q - 1'b1;
            addr_q <= addr_q + 1'b1;
        end
    end

    // capture header zero and the length byte, which is passed through unchanged
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            len_q <= '0;
            hz_q <= '0;
        end else if (start_task) begin
            len_q <= '0;
            hz_q <= '0;
        end else if (fire && fs_q == F_S0 && rem_q == {1'b0, s0_by}) begin
            hz_q <= pass;
        end else if (fire && fs_q == F_LEN && rem_q == {1'b0, lf_by}) begin
            len_q <= pass;
        end
    end

    // crc length and truncation status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_len_bytes <= '0;
            truncated <= 1'b0;
        end else if (fs_q == F_S1 && rem_q == '0) begin
            crc_len_bytes <= pay_tot;
            truncated <= (req_tot > {1'b0, payload_byte_cap});
        end
    end

    // memory side handshake; fifo carries the bytes both ways
    assign mem_req = (fs_q != F_IDLE) && (rem_q != '0) && (txdir_q ? st.in_ready : st.out_valid);
    assign mem_we = !txdir_q;
    assign mem_addr = addr_q;
    assign mem_wdata = st.out_data;
    assign st.in_valid = txdir_q ? fire : air_rx_valid;
    assign st.in_data = txdir_q ? mem_rdata : air_rx_byte;
    assign st.out_ready = txdir_q ? air_tx_ready : fire;
    assign air_tx_valid = txdir_q & st.out_valid;
    assign air_tx_byte = st.out_data;
    assign air_rx_ready = !txdir_q & st.in_ready;

    rpsa_fifo #(.W(BYTE_W), .D(FIFO_D)) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(start_task | stop_task | disable_task),
        .s(st)
    );

    // address bytes, little-endian: first byte is least significant
    assign da_on = !txdir_q && (byte_order_sel == ORDER_LITTLE);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            da_n_q <= '0;
            da_full_q <= 1'b0;
            da_sh_q <= '0;
            da_go_q <= 1'b0;
        end else begin
            da_go_q <= 1'b0;
            if (start_task) begin
                da_n_q <= '0;
                da_full_q <= 1'b0;
            end else if (fire && fs_q == F_PAY && da_on && !da_full_q) begin
                da_sh_q <= {pass, da_sh_q[DA_BITS-1:BYTE_W]};
                da_n_q <= da_n_q + 1'b1;
                da_full_q <= (da_n_q == DA_LAST);
                da_go_q <= (da_n_q == DA_LAST);
            end
        end
    end

    // all entries compared in parallel
    generate
        for (genvar i = 0; i < DA_ENTRIES; i++) begin : g_da
            assign da_hit[i] = devaddr_match_config[DACFG_EN_LSB + i]
                && da_sh_q == {devaddr_high_half[i*DA_HIGH_W +: DA_HIGH_W],
                               devaddr_low_word[i*DA_LOW_W +: DA_LOW_W]}
                && devaddr_match_config[DACFG_TX_ADDRESS_TYPE_BIT_LSB + i] == hz_q[TX_ADDRESS_TYPE_BIT_BIT];
        end
    endgenerate

    // match result, lowest matching entry reported
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            devmatch_event <= 1'b0;
            devmiss_event <= 1'b0;
            devmatch_index <= '0;
        end else begin
            devmatch_event <= da_go_q & (|da_hit);
            devmiss_event <= da_go_q & ~(|da_hit);
            if (da_go_q) begin
                for (int k = DA_ENTRIES - 1; k >= 0; k--) begin
                    if (da_hit[k]) begin
                        devmatch_index <= DA_IDX_W'(k);
                    end
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_gap_len;
        last_air_bit && !txdir_q && gap_en && gap_q == '0 |=> gap_q == GAPCNT_W'(gap_eff) * CYC_US;
    endproperty
    a_gap_len: assert property (p_gap_len) else $error("gap not loaded with effective length");
    property p_gap_floor;
        gap_eff >= TURN && (interframe_gap_us >= TURN || gap_eff == TURN);
    endproperty
    a_gap_floor: assert property (p_gap_floor) else $error("gap below turnaround");
    property p_gap_off;
        last_air_bit && !gap_en && gap_q == '0 |=> gap_q == '0;
    endproperty
    a_gap_off: assert property (p_gap_off) else $error("gap started without shortcuts");
    property p_first_bit;
        gap_q == GAPCNT_W'(1) && !last_air_bit |=> tx_first_bit && !gap_busy;
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first bit not released at gap end");
    property p_end_ev;
        last_air_bit |=> end_event ##1 bit_count == '0 && !bc_run_q;
    endproperty
    a_end_ev: assert property (p_end_ev) else $error("end event or counter clear missing");
    property p_dis_ack;
        disable_task |=> disabled_event && fs_q == F_IDLE;
    endproperty
    a_dis_ack: assert property (p_dis_ack) else $error("disable not acknowledged");
    property p_bc_hit;
        bc_run_q && air_bit_tick && !bitcount_halt_task && !stop_task && !disable_task && !end_event
        && !bitcount_begin_task && bit_count + 1'b1 == bitcount_compare |=> bitcount_hit_event;
    endproperty
    a_bc_hit: assert property (p_bc_hit) else $error("bit counter hit missed");
    property p_mode;
        !transmit_rampup_task && !receive_rampup_task |=> $stable(mode_active);
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed outside ramp-up");
    property p_ptr;
        start_task && !stop_task && !disable_task |=> mem_addr == $past(packet_ram_pointer);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not taken at start");
    property p_match_mode;
        devmatch_event || devmiss_event |-> $past(da_on, 2);
    endproperty
    a_match_mode: assert property (p_match_mode) else $error("address match outside little-endian rx");
    property p_cap;
        fs_q == F_PAY |-> rem_q <= {1'b0, payload_byte_cap};
    endproperty
    a_cap: assert property (p_cap) else $error("payload region beyond cap");
endmodule

// ===== rpsa_mem_model.sv
// memory partner for the transfer engine: slow grants, bytes tied to their address
`timescale 1ns/1ps
module rpsa_mem_model (
    input wire logic clk,  // system clock
    input wire logic rst_b,  // async reset, active low
    input wire logic req,  // access request
    input wire logic [31:0] addr,  // byte address
    output logic gnt,  // access done this cycle
    output logic [7:0] rdata  // read byte
);
    logic ph_q;  // wait phase, so every request must be held
    // grant every second request cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= req & ~ph_q;
        end
    end
    assign gnt = req & ph_q;
    // length byte at 0x101, other bytes their address; a changing pattern outside grants
    assign rdata = !gnt ? (8'hA5 ^ addr[7:0]) : (addr == 32'h101) ? 8'h0A : addr[7:0];
endmodule

// ===== test_radio_packet_sequencer_aux.sv
// bench for the packet support logic with a memory partner
`timescale 1ns/1ps
module test_radio_packet_sequencer_aux;
    import rpsa_pkg::*;
    logic clk = 0, rst_b = 0;  // clock, reset
    logic [8:0] tk = '0;  // task pulses
    logic [GAP_W-1:0] interframe_gap_us = '0;  // gap setting
    logic [SC_W-1:0] shortcut_links = '0;  // shortcut setting
    logic [MODE_W-1:0] mode_sel = '0;  // staged mode
    logic [BC_W-1:0] bitcount_compare = '0;  // compare value
    logic byte_order_sel = ORDER_LITTLE;  // little endian
    logic [255:0] devaddr_low_word = {8{32'h44332211}};  // same low word in all entries
    logic [127:0] devaddr_high_half = {8{16'h6655}};  // same high part in all entries
    logic [15:0] devaddr_match_config = 16'h0404;  // only entry 2 enabled, type bit set
    logic [31:0] packet_ram_pointer = 32'h100;  // staged pointer
    logic [3:0] hdr_zero_bits = 4'h8, length_field_bits = 4'h8, hdr_one_bits = 4'h0;  // field sizes
    logic [7:0] static_addon_len = 8'h00, payload_byte_cap = 8'h08, air_rx_byte = 8'h00;  // sizes, rx byte
    logic air_tx_ready = 0, air_rx_valid = 0;  // air handshakes
    wire [MODE_W-1:0] mode_active;
    wire end_event, disabled_event, gap_busy, tx_first_bit, bitcount_hit_event, devmatch_event, devmiss_event;
    wire truncated, mem_req, mem_we, mem_gnt, air_tx_valid, air_rx_ready;
    wire [BC_W-1:0] bit_count;
    wire [2:0] devmatch_index;
    wire [7:0] crc_len_bytes, mem_rdata, mem_wdata, air_tx_byte;
    wire [31:0] mem_addr;
    int err_total = 0, checked = 0, cyc = 0, n_end = 0, n_dis = 0, n_hit = 0, n_match = 0, n_miss = 0, n_grant = 0;
    logic [7:0] txq[$];  // bytes taken by the modulator
    logic [7:0] rxb[8] = '{8'h40, 8'h06, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};  // received packet
    typedef struct {logic [15:0] g; logic [2:0] s; int n;} rpsa_row_s;
    rpsa_row_s rows[4] = '{'{16'h0, 3'h5, 100}, '{16'h2, 3'h3, 200}, '{16'h1, 3'h1, 300}, '{16'h1, 3'h6, 300}};
    rpsa_top #(.FIFO_D(4), .TURN_US(1)) DUT (.clk, .rst_b, .interframe_gap_us, .shortcut_links, .mode_sel,
        .mode_active, .transmit_rampup_task(tk[0]), .receive_rampup_task(tk[1]), .start_task(tk[2]),
        .stop_task(tk[3]), .disable_task(tk[4]), .last_air_bit(tk[5]), .air_bit_tick(tk[6]), .end_event,
        .disabled_event, .gap_busy, .tx_first_bit, .bitcount_begin_task(tk[7]), .bitcount_halt_task(tk[8]),
        .bitcount_compare, .bitcount_hit_event, .bit_count, .byte_order_sel, .devaddr_low_word,
        .devaddr_high_half, .devaddr_match_config, .devmatch_event, .devmiss_event, .devmatch_index,
        .packet_ram_pointer, .hdr_zero_bits, .length_field_bits, .hdr_one_bits, .static_addon_len,
        .payload_byte_cap, .crc_len_bytes, .truncated, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_gnt,
        .mem_rdata, .air_tx_valid, .air_tx_ready, .air_tx_byte, .air_rx_valid, .air_rx_ready, .air_rx_byte);
    rpsa_mem_model MEM (.clk, .rst_b, .req(mem_req), .addr(mem_addr), .gnt(mem_gnt), .rdata(mem_rdata));
    always #5 clk = ~clk;
    // event, grant and air byte tallies, plus the hang guard
    always @(posedge clk) begin
        cyc++;
        if (end_event) n_end++;
        if (disabled_event) n_dis++;
        if (bitcount_hit_event) n_hit++;
        if (devmatch_event) n_match++;
        if (devmiss_event) n_miss++;
        // received bytes land in order from the pointer
        if (mem_req && mem_gnt && mem_we) begin
            chk("rx_addr", 32'h100 + n_grant % 8, mem_addr);
            chk("rx_wdata", rxb[n_grant % 8], mem_wdata);
        end
        if (mem_req && mem_gnt) n_grant++;
        if (air_tx_valid && air_tx_ready) txq.push_back(air_tx_byte);
        if (cyc > 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle task pulse, then one quiet cycle
    task automatic pulse(input int b);
        tk[b] = 1'b1;
        @(posedge clk); #1;
        tk[b] = 1'b0;
        @(posedge clk); #1;
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        int n;
        repeat (20) @(posedge clk);
        #1 rst_b = 1;
        chk("mode_active", 0, mode_active);
        // gap table: length, shortcut qualification, turnaround floor
        foreach (rows[i]) begin
            interframe_gap_us = rows[i].g;
            shortcut_links = rows[i].s;
            pulse(5);
            chk("gap_busy", rows[i].n < 300, gap_busy);
            n = 1;  // the pulse already spent one edge after the sampling edge
            while (tx_first_bit !== 1'b1 && n < 300) begin
                @(posedge clk); #1;
                n++;
            end
            chk("gap_cycles", rows[i].n, n);
        end
        chk("end_count", 4, n_end);
        mode_sel = 4'h5;
        pulse(1);
        mode_sel = 4'h9;
        chk("mode_active", 5, mode_active);
        // three receptions: match, type bit mismatch, big-endian with no matching
        for (int p = 0; p < 3; p++) begin
            pulse(2);
            foreach (rxb[i]) begin
                air_rx_byte = rxb[i];
                air_rx_valid = 1'b1;
                while (air_rx_ready !== 1'b1) begin
                    @(posedge clk); #1;
                end
                @(posedge clk); #1;
            end
            air_rx_valid = 1'b0;
            repeat (40) @(posedge clk);
            #1 chk("devmatch", 1, n_match);
            chk("devmiss", p > 0, n_miss);
            chk("devmatch_index", 2, devmatch_index);
            chk("rx_grants", 8 * (p + 1), n_grant);
            devaddr_match_config = 16'h0004;  // type bit no longer equals header bit 6
            byte_order_sel = (p == 1) ? ~ORDER_LITTLE : ORDER_LITTLE;  // last packet big-endian
        end
        pulse(3);
        // bit counter: hit, new compare, halt, end clears
        bitcount_compare = 20'h2;
        pulse(7);
        repeat (3) pulse(6);
        chk("hits", 1, n_hit);
        bitcount_compare = 20'h5;
        repeat (2) pulse(6);
        chk("hits", 2, n_hit);
        chk("bit_count", 5, bit_count);
        pulse(8);
        pulse(6);
        chk("bit_count", 0, bit_count);
        pulse(7);
        pulse(6);
        pulse(5);
        chk("bit_count", 0, bit_count);
        pulse(4);
        chk("disabled", 1, n_dis);
        // truncated transmit with the modulator stalling first
        pulse(0);
        chk("mode_active", 9, mode_active);
        static_addon_len = 8'h02;
        payload_byte_cap = 8'h05;
        n_grant = 0;
        txq.delete();
        pulse(2);
        packet_ram_pointer = 32'h200;
        repeat (30) @(posedge clk);
        #1 air_tx_ready = 1'b1;
        repeat (100) @(posedge clk);
        #1 chk("truncated", 1, truncated);
        chk("crc_len", 5, crc_len_bytes);
        chk("tx_grants", 7, n_grant);
        chk("tx_bytes", 7, txq.size());
        foreach (txq[i]) chk("tx_byte", (i == 1) ? 8'h0A : i, txq[i]);
        report_and_stop();
    end
endmodule
